// ===== eiotc_top.v
// External control port trigger and result conditioning
`timescale 1ns/10ps
`include "eiotc_map.vh"
// Summary of operation
// - Trigger starts on on-edge or off-edge
// - On-edge is rising for source, falling sink
// - Reset selects on-edge triggering
// - Filter needs trigger held active response time
// - Filter disabled after reset
// - Response time 1 to 500 ms, default 1
// - Normal polarity: contact pass drives active
// - Inverted polarity flips contact and voltage pass
// - Open-correction pass never inverted
// - Contact check disabled forces contact output inactive
// - Hold mode keeps end-of-measurement until trigger
// - Pulse mode drops it after pulse width
// - Pulse width 1 to 100 ms, default 1
// - Test mode forces each output individually
// - Test mode reports live input states
// - Test mode rejects remote commands and queries
// - Active is high for source, low sink
// - Accepted trigger drives end and acquisition inactive
module eiotc_top #(
    parameter MS_CYCLES = `EIOTC_MS_CYCLES,
    parameter NCHAN = `EIOTC_NCHAN
) (
    input wire clk,
    input wire resetn,
    input wire measurement_trigger_in,
    input wire sink_polarity,
    input wire measurement_trigger_in_on_edge_sel_n,
    input wire filter_en,
    input wire [8:0] filter_ms,
    input wire pulse_mode,
    input wire [8:0] pulse_ms,
    input wire pass_invert,
    input wire [NCHAN-1:0] contact_check_en,
    input wire startup_done,
    input wire meas_done,
    input wire acq_done,
    input wire meas_err,
    input wire open_pass,
    input wire [NCHAN-1:0] contact_pass,
    input wire [NCHAN-1:0] volt_pass,
    input wire port_test_en,
    input wire [15:0] test_out_val,
    input wire remote_req,
    output wire remote_accept,
    output wire remote_reject,
    output reg trigger_pulse,
    output reg trigger_in_active,
    output reg [15:0] ext_out_level,
    output reg [15:0] ext_out_active
);
    // Synchroniser: a change counts once the second and third stages agree
    reg measurement_trigger_in_s1_r, measurement_trigger_in_s2_r, measurement_trigger_in_s3_r, measurement_trigger_in_lvl_r;
    always @(posedge clk) begin
        if (!resetn) begin
            // Preset to the idle voltage so no false edge follows reset
            measurement_trigger_in_s1_r <= sink_polarity;
            measurement_trigger_in_s2_r <= sink_polarity;
            measurement_trigger_in_s3_r <= sink_polarity;
        end else begin
            measurement_trigger_in_s1_r <= measurement_trigger_in;
            measurement_trigger_in_s2_r <= measurement_trigger_in_s1_r;
            measurement_trigger_in_s3_r <= measurement_trigger_in_s2_r;
        end
    end
    // Logical state to pin voltage and back: source drives high for active, sink low
    function eiotc_pin;
        input act;
        input sink;
        begin
            eiotc_pin = act ^ sink;
        end
    endfunction

    // Voltage level to logical active: high is active for source, low for sink
    wire measurement_trigger_in_act_now = (measurement_trigger_in_s2_r == measurement_trigger_in_s3_r) ? eiotc_pin(measurement_trigger_in_s2_r, sink_polarity) : measurement_trigger_in_lvl_r;
    reg measurement_trigger_in_prev_r;
    always @(posedge clk) begin
        if (!resetn) begin
            measurement_trigger_in_lvl_r <= 1'b0;
            measurement_trigger_in_prev_r <= 1'b0;
            trigger_in_active <= 1'b0;
        end else begin
            measurement_trigger_in_lvl_r <= measurement_trigger_in_act_now;
            measurement_trigger_in_prev_r <= measurement_trigger_in_lvl_r;
            trigger_in_active <= measurement_trigger_in_lvl_r;
        end
    end
    // Logical edges; polarity already folded into measurement_trigger_in_lvl_r
    wire on_edge = measurement_trigger_in_lvl_r & ~measurement_trigger_in_prev_r;
    wire off_edge = ~measurement_trigger_in_lvl_r & measurement_trigger_in_prev_r;
    // Reset default of the selection port is low, giving on-edge
    wire edge_hit = measurement_trigger_in_on_edge_sel_n ? off_edge : on_edge;

    function [8:0] eiotc_clamp;
        input [8:0] v;
        input [8:0] lo;
        input [8:0] hi;
        begin
            if (v < lo)
                eiotc_clamp = lo;
            else if (v > hi)
                eiotc_clamp = hi;
            else
                eiotc_clamp = v;
        end
    endfunction
    wire [8:0] filt_lim = eiotc_clamp(filter_ms, `EIOTC_FILT_MS_MIN, `EIOTC_FILT_MS_MAX);
    wire [8:0] pulse_lim = eiotc_clamp(pulse_ms, `EIOTC_PULSE_MS_MIN, `EIOTC_PULSE_MS_MAX);

    // True when the trigger is inactive or filtering is off
    function eiotc_drop;
        input en;
        input lvl;
        begin
            eiotc_drop = ~en | ~lvl;
        end
    endfunction

    // Filter: count whole ms while active; restart on any drop
    wire filt_tick;
    wire filt_clear = eiotc_drop(filter_en, measurement_trigger_in_lvl_r);
    eiotc_ms_tick #(.MS_CYCLES(MS_CYCLES), .W(`EIOTC_TICK_W)) u_filt_tick (
        .clk(clk),
        .resetn(resetn),
        .clear(filt_clear),
        .tick(filt_tick)
    );
    localparam [1:0] FLT_IDLE = 2'b00;
    localparam [1:0] FLT_RUN = 2'b01;
    localparam [1:0] FLT_MET = 2'b10;
    localparam [1:0] FLT_DONE = 2'b11;
    reg [1:0] flt_state_r, flt_state_nxt;
    reg [8:0] flt_ms_r, flt_ms_nxt;
    always @* begin
        flt_state_nxt = flt_state_r;
        flt_ms_nxt = flt_ms_r;
        case (flt_state_r)
            FLT_IDLE: begin
                flt_ms_nxt = 9'h000;
                if (!filt_clear) begin
                    flt_state_nxt = FLT_RUN;
                end
            end
            FLT_RUN: begin
                if (filt_clear) begin
                    flt_state_nxt = FLT_IDLE;
                    flt_ms_nxt = 9'h000;
                end else if (flt_ms_r >= filt_lim) begin
                    flt_state_nxt = FLT_MET;
                end else if (filt_tick) begin
                    flt_ms_nxt = flt_ms_r + 9'h001;
                end
            end
            FLT_MET: begin
                if (filt_clear) begin
                    flt_state_nxt = FLT_IDLE;
                end else begin
                    flt_state_nxt = FLT_DONE;
                end
            end
            default: begin
                if (filt_clear) begin
                    flt_state_nxt = FLT_IDLE;
                end
            end
        endcase
    end
    always @(posedge clk) begin
        if (!resetn) begin
            flt_state_r <= FLT_IDLE;
            flt_ms_r <= 9'h000;
        end else begin
            flt_state_r <= flt_state_nxt;
            flt_ms_r <= flt_ms_nxt;
        end
    end
    // Met lasts one cycle; met or done means qualified until release
    wire filt_ok = (flt_state_r == FLT_MET);
    wire filt_pend = filt_ok | (flt_state_r == FLT_DONE);
    reg measurement_trigger_in_accept;
    always @* begin
        if (!filter_en) begin
            measurement_trigger_in_accept = edge_hit;
        end else if (measurement_trigger_in_on_edge_sel_n) begin
            measurement_trigger_in_accept = off_edge & filt_pend;
        end else begin
            measurement_trigger_in_accept = filt_ok;
        end
    end
    always @(posedge clk) begin
        if (!resetn)
            trigger_pulse <= 1'b0;
        else
            trigger_pulse <= measurement_trigger_in_accept & ~port_test_en;
    end

    // End-of-measurement output: boot, off, held, or timed pulse
    localparam [1:0] EOM_BOOT = 2'b00;
    localparam [1:0] EOM_OFF = 2'b01;
    localparam [1:0] EOM_HOLD = 2'b10;
    localparam [1:0] EOM_PULSE = 2'b11;
    reg [1:0] eom_state_r, eom_state_nxt;
    reg [8:0] eom_ms_r, eom_ms_nxt;
    reg acq_r, acq_nxt;
    wire eom_on = (eom_state_r == EOM_HOLD) | (eom_state_r == EOM_PULSE);
    wire eom_tick;
    eiotc_ms_tick #(.MS_CYCLES(MS_CYCLES), .W(`EIOTC_TICK_W)) u_eom_tick (
        .clk(clk),
        .resetn(resetn),
        .clear(eom_state_r != EOM_PULSE),
        .tick(eom_tick)
    );
    always @* begin
        eom_state_nxt = eom_state_r;
        eom_ms_nxt = eom_ms_r;
        acq_nxt = acq_r;
        case (eom_state_r)
            EOM_BOOT: begin
                if (startup_done) begin
                    acq_nxt = 1'b1;
                    eom_ms_nxt = 9'h000;
                    eom_state_nxt = pulse_mode ? EOM_PULSE : EOM_HOLD;
                end
            end
            default: begin
                // A trigger in the same cycle as a finished measurement wins
                if (trigger_pulse) begin
                    acq_nxt = 1'b0;
                    eom_state_nxt = EOM_OFF;
                end else if (meas_done) begin
                    acq_nxt = 1'b1;
                    eom_ms_nxt = 9'h000;
                    eom_state_nxt = pulse_mode ? EOM_PULSE : EOM_HOLD;
                end else begin
                    if (acq_done) begin
                        acq_nxt = 1'b1;
                    end
                    if (eom_state_r == EOM_PULSE && eom_tick) begin
                        if (eom_ms_r + 9'h001 >= pulse_lim) begin
                            eom_state_nxt = EOM_OFF;
                        end else begin
                            eom_ms_nxt = eom_ms_r + 9'h001;
                        end
                    end
                end
            end
        endcase
    end
    always @(posedge clk) begin
        if (!resetn) begin
            eom_state_r <= EOM_BOOT;
            eom_ms_r <= 9'h000;
            acq_r <= 1'b0;
        end else begin
            eom_state_r <= eom_state_nxt;
            eom_ms_r <= eom_ms_nxt;
            acq_r <= acq_nxt;
        end
    end

    // Pass, end, acquisition and error outputs
    wire [NCHAN-1:0] cc_judge = contact_pass & contact_check_en;
    wire [NCHAN-1:0] cc_act = (cc_judge ^ {NCHAN{pass_invert}}) & contact_check_en;
    wire [NCHAN-1:0] vc_act = volt_pass ^ {NCHAN{pass_invert}};
    reg [15:0] norm_act;
    integer ch;
    always @* begin
        norm_act = 16'h0000;
        norm_act[`EIOTC_OUT_EOM] = eom_on;
        norm_act[`EIOTC_OUT_ACQ] = acq_r;
        norm_act[`EIOTC_OUT_OPEN] = open_pass;
        for (ch = 0; ch < NCHAN; ch = ch + 1) begin
            norm_act[`EIOTC_OUT_CC + ch] = cc_act[ch];
            norm_act[`EIOTC_OUT_VC + ch] = vc_act[ch];
        end
        norm_act[`EIOTC_OUT_ERR] = meas_err;
    end

    // Test mode overrides each line individually
    wire [15:0] act_sel = port_test_en ? test_out_val : norm_act;
    reg [15:0] pin_lvl;
    integer ln;
    always @* begin
        pin_lvl = 16'h0000;
        for (ln = 0; ln < `EIOTC_NOUT; ln = ln + 1) begin
            pin_lvl[ln] = eiotc_pin(act_sel[ln], sink_polarity);
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            ext_out_active <= 16'h0000;
            ext_out_level <= 16'h0000;
        end else begin
            ext_out_active <= act_sel;
            ext_out_level <= pin_lvl;
        end
    end

    // Remote traffic bounces while port test owns the lines
    assign remote_accept = remote_req & ~port_test_en;
    assign remote_reject = remote_req & port_test_en;
endmodule // eiotc_top

// ===== eiotc_map.vh
// Constants for the external control port conditioning block
`ifndef EIOTC_MAP_VH
`define EIOTC_MAP_VH
`define EIOTC_CLK_HZ 100000000
`define EIOTC_MS_CYCLES (`EIOTC_CLK_HZ / 1000)
`define EIOTC_TICK_W 17
`define EIOTC_MS_W 9
`define EIOTC_FILT_MS_MIN 9'h001
`define EIOTC_FILT_MS_MAX 9'h1f4
`define EIOTC_PULSE_MS_MIN 9'h001
`define EIOTC_PULSE_MS_MAX 9'h064
`define EIOTC_NCHAN 4
`define EIOTC_NOUT 16
`define EIOTC_NIN 1
`define EIOTC_OUT_EOM 0
`define EIOTC_OUT_ACQ 1
`define EIOTC_OUT_OPEN 2
`define EIOTC_OUT_CC 3
`define EIOTC_OUT_VC 7
`define EIOTC_OUT_ERR 11
`endif

// ===== eiotc_ms_tick.v
// Millisecond enable pulse divider
`timescale 1ns/10ps
module eiotc_ms_tick #(
    parameter MS_CYCLES = 100000,
    parameter W = 17
) (
    input wire clk,
    input wire resetn,
    input wire clear,
    output reg tick
);
    localparam [W-1:0] TERM = MS_CYCLES - 1;
    reg [W-1:0] cnt_r;
    always @(posedge clk) begin
        if (!resetn || clear) begin
            cnt_r <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_r == TERM) begin
            cnt_r <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // eiotc_ms_tick

// ===== eiotc_plc.sv
// Far-side switch model that drives the trigger pin
`timescale 1ns/10ps
module eiotc_plc (
    input wire sink_polarity,
    input wire on_req,
    output wire measurement_trigger_in
);
    // A closed contact puts the pin at the active voltage
    assign measurement_trigger_in = on_req ^ sink_polarity;
endmodule // eiotc_plc

// ===== eiotc_top_chk.sv
// Port assertions for the trigger and result conditioning block
`timescale 1ns/10ps
module eiotc_top_chk #(
    parameter MS_CYCLES = 10,
    parameter NCHAN = 4
) (
    input wire clk,
    input wire resetn,
    input wire sink_polarity,
    input wire port_test_en,
    input wire remote_req,
    input wire remote_accept,
    input wire remote_reject,
    input wire trigger_pulse,
    input wire meas_done,
    input wire [NCHAN-1:0] contact_check_en,
    input wire [15:0] ext_out_active,
    input wire [15:0] ext_out_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_ACC: assert property (remote_accept == (remote_req && !port_test_en)) else $error("accept wrong");
    AST_REJ: assert property (remote_reject == (remote_req && port_test_en)) else $error("reject wrong");
    AST_LVL: assert property ($past(resetn) && $past(resetn, 2) && $past(resetn, 3) && $stable(sink_polarity)
        && $stable(ext_out_active) |-> ext_out_level == (ext_out_active ^ {16{sink_polarity}}))
        else $error("pin level wrong");
    AST_TPUL: assert property (trigger_pulse |=> !trigger_pulse) else $error("trigger pulse too long");
    AST_TST: assert property ($past(port_test_en) |-> !trigger_pulse) else $error("trigger in test mode");
    AST_CLR: assert property (trigger_pulse |-> ##[1:3] !ext_out_active[0]) else $error("end not cleared");
    AST_SET: assert property (meas_done && !port_test_en |-> ##[1:3] ext_out_active[1:0] == 2'h3)
        else $error("end not set");
    AST_CCD: assert property (!contact_check_en[0] && !$past(contact_check_en[0]) && !port_test_en
        && !$past(port_test_en) |-> !ext_out_active[3]) else $error("disabled contact active");
    cover property (trigger_pulse);
    cover property (remote_reject);
    cover property (meas_done ##2 ext_out_active[0]);
endmodule // eiotc_top_chk
bind eiotc_top eiotc_top_chk #(.MS_CYCLES(MS_CYCLES), .NCHAN(NCHAN)) u_chk (.*);

// ===== tb_top.sv
// Self-checking bench for the trigger and result conditioning block
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic clk = 0, resetn = 0, on_req = 0, sink_polarity = 0, measurement_trigger_in_on_edge_sel_n = 0, filter_en = 0;
    logic pulse_mode = 0, pass_invert = 0, startup_done = 0, meas_done = 0, acq_done = 0, meas_err = 0;
    logic open_pass = 0, port_test_en = 0, remote_req = 0;
    logic [8:0] filter_ms = 9'h001, pulse_ms = 9'h001;
    logic [3:0] contact_check_en = 4'hf, contact_pass = 4'h0, volt_pass = 4'h0;
    logic [15:0] test_out_val = 16'h0000;
    wire measurement_trigger_in, remote_accept, remote_reject, trigger_pulse, trigger_in_active;
    wire [15:0] ext_out_level, ext_out_active;
    int fail_count = 0, compares = 0, cyc = 0, tcnt = 0, t0;
    // sink, invert, check enable, contact, voltage, open, then expected voltage, contact, open
    logic [23:0] rows [4] = '{24'h3e96b5, 24'hfe974b, 24'h4c3c06, 24'h9be52c};
    eiotc_top #(.MS_CYCLES(10), .NCHAN(4)) DUT (.*);
    eiotc_plc u_plc (.*);
    always #5 clk = ~clk;
    task automatic wrap_up;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic w(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fin(string s);
        $display("test %s finished", s);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (trigger_pulse === 1'b1) tcnt <= tcnt + 1;
        if (cyc == 2000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        w(12);
        `CHK({trigger_pulse, ext_out_active}, 17'h0);
        resetn = 1;
        w(2);
        startup_done = 1;
        w(3);
        `CHK(ext_out_active[1:0], 2'h3);
        fin("startup");
        foreach (rows[i]) begin
            {sink_polarity, pass_invert, contact_check_en, contact_pass, volt_pass, open_pass} = rows[i][23:9];
            w(4);
            `CHK(ext_out_active[10:2], rows[i][8:0]);
            `CHK(ext_out_level[10:2], rows[i][8:0] ^ {9{sink_polarity}});
            `CHK(ext_out_active[15:11], 5'h00);
        end
        fin("table");
        for (int k = 0; k < 4; k++) begin
            {sink_polarity, measurement_trigger_in_on_edge_sel_n} = 2'(k);
            w(8);
            meas_done = 1;
            w(1);
            meas_done = 0;
            w(3);
            `CHK(ext_out_active[0], 1'b1);
            t0 = tcnt;
            on_req = 1;
            w(15);
            `CHK(tcnt - t0, k[0] ? 0 : 1);
            `CHK(trigger_in_active, 1'b1);
            on_req = 0;
            w(15);
            `CHK(tcnt - t0, 1);
            `CHK(ext_out_active[0], 1'b0);
            `CHK(ext_out_active[1], 1'b0);
            acq_done = 1;
            meas_err = k[0];
            w(1);
            acq_done = 0;
            w(3);
            `CHK(ext_out_active[1], 1'b1);
            `CHK(ext_out_active[11], k[0]);
        end
        meas_err = 0;
        fin("edges");
        {sink_polarity, measurement_trigger_in_on_edge_sel_n} = 2'h0;
        filter_en = 1;
        filter_ms = 9'h002;
        w(8);
        t0 = tcnt;
        on_req = 1;
        w(15);
        on_req = 0;
        w(4);
        on_req = 1;
        w(15);
        on_req = 0;
        w(5);
        `CHK(tcnt - t0, 0);
        on_req = 1;
        w(30);
        `CHK(tcnt - t0, 1);
        on_req = 0;
        filter_en = 0;
        w(8);
        fin("filter");
        pulse_mode = 1;
        pulse_ms = 9'h003;
        meas_done = 1;
        w(1);
        meas_done = 0;
        w(20);
        `CHK(ext_out_active[0], 1'b1);
        w(15);
        `CHK(ext_out_active[0], 1'b0);
        fin("pulse");
        pulse_mode = 0;
        port_test_en = 1;
        test_out_val = 16'h05a3;
        remote_req = 1;
        t0 = tcnt;
        w(3);
        `CHK(ext_out_active, 16'h05a3);
        `CHK({remote_accept, remote_reject}, 2'b01);
        on_req = 1;
        w(8);
        `CHK(trigger_in_active, 1'b1);
        `CHK(tcnt - t0, 0);
        on_req = 0;
        w(8);
        port_test_en = 0;
        w(1);
        `CHK({remote_accept, remote_reject}, 2'b10);
        fin("port test");
        resetn = 0;
        w(3);
        `CHK({trigger_pulse, ext_out_active}, 17'h0);
        resetn = 1;
        w(4);
        fin("reset");
        wrap_up();
    end
endmodule // tb_top
